// file: rtl/ls_align_regs.svh
/*
  Constants for the load/store alignment and endian datapath.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LS_ALIGN_REGS_SVH
`define LS_ALIGN_REGS_SVH
// -----------------------------------------------------------------
// Access size codes
// -----------------------------------------------------------------
`define SIZE_BYTE 3'h1
`define SIZE_HALF 3'h2
`define SIZE_WORD 3'h4
// -----------------------------------------------------------------
// Field widths and reset values
// -----------------------------------------------------------------
`define DATA_W 32
`define LANE_SHIFT_W 5
`define RESET_DATA 32'h0000_0000
`define RESET_ADDR 32'h0000_0000
`endif

// file: rtl/ls_align_pkg.sv
/*
  Types for the load/store alignment and endian datapath.
  Assumes the constants header is on the include path.
*/
`include "ls_align_regs.svh"
package ls_align_pkg;
  // Byte-order model selected by the legacy and state bits.
  typedef enum logic [1:0]
  {
    little_endian_model = 2'b00,
    byte_invariant_big_endian = 2'b01,
    word_invariant_big_endian = 2'b10,
    endian_reserved = 2'b11
  } endian_e;

  // One access request from the pipeline.
  typedef struct packed
  {
    logic valid;
    logic isStore;
    logic multiWord;
    logic [2:0] size;
    logic [31:0] addr;
    logic [31:0] storeData;
  } ls_req_s;

  // One formatted access toward memory and back to the pipeline.
  typedef struct packed
  {
    logic valid;
    logic isStore;
    logic [31:0] addr;
    logic [3:0] byteEnable;
    logic [31:0] storeData;
    logic [31:0] loadData;
    logic sizeError;
    logic alignError;
  } ls_rsp_s;
endpackage

// file: rtl/lane_shifter.sv
/*
  Zero-filling logical shifter used to steer bytes between lanes.
  Assumes a combinational context; the caller registers the result.
*/
`timescale 1ns/1ps
`include "ls_align_regs.svh"
module lane_shifter #(
  parameter int WIDTH = 32
) (
  input wire logic [WIDTH-1:0] dataIn,
  input wire logic [$clog2(WIDTH)-1:0] amount,
  input wire logic shiftLeft,
  output logic [WIDTH-1:0] dataOut
);
  // Refuse widths too narrow to carry a shift amount.
  if (WIDTH < 2)
  begin
    $error("The lane shifter needs at least two bits.");
  end

  // -----------------------------------------------------------------
  // Shift
  // -----------------------------------------------------------------
  // Vacated positions always take zeros in either direction.
  always_comb
  begin
    if (shiftLeft)
    begin
      dataOut = dataIn << amount;
    end
    else
    begin
      dataOut = dataIn >> amount;
    end
  end
endmodule

// file: rtl/load_store_align_endian.sv
/*
  Load/store data formatter: size, alignment, byte order and zero extension.
  Assumes the pipeline holds its request for one cycle and that memory returns
  the full 32-bit word at the word address with loads, in the same cycle.
*/
`timescale 1ns/1ps
`include "ls_align_regs.svh"
module load_store_align_endian #(
  parameter int DATA_WIDTH = `DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic unalignedAccessEnable,
  input wire logic legacyBigEndian,
  input wire logic dataEndianState,
  input wire ls_align_pkg::ls_req_s req,
  input wire logic [31:0] memReadData,
  output ls_align_pkg::ls_rsp_s rsp,
  output ls_align_pkg::endian_e endianModel
);
  import ls_align_pkg::*;

  // Refuse widths that the fixed four byte lanes cannot serve.
  if (DATA_WIDTH != 32)
  begin
    $error("Only a 32-bit datapath is supported.");
  end

  // -----------------------------------------------------------------
  // Model and alignment
  // -----------------------------------------------------------------
  endian_e model;
  logic sizeOk;
  logic isHalf;
  logic isWord;
  logic [31:0] effAddr;
  logic [1:0] lane;
  logic misaligned;
  logic [3:0] bytesMask;
  logic [1:0] itemBytes;

  // Decode the byte-order model and the effective address.
  always_comb
  begin
    model = endian_e'({legacyBigEndian, dataEndianState});
    isHalf = (req.size == `SIZE_HALF);
    isWord = (req.size == `SIZE_WORD);
    sizeOk = (req.size == `SIZE_BYTE) || isHalf || isWord;
    // Misalignment is only flagged for multi-word transfers and the reserved model.
    misaligned = (isHalf && req.addr[0]) || (isWord && (req.addr[1:0] != 2'b00));
    effAddr = req.addr;
    if (!unalignedAccessEnable || req.multiWord)
    begin
      if (isHalf)
      begin
        effAddr[0] = 1'b0;
      end
      else if (isWord)
      begin
        effAddr[1:0] = 2'b00;
      end
    end
    // With unaligned access on and no multi-word transfer, the exact byte address stands.
    lane = effAddr[1:0];
    // Word-invariant big endian mirrors byte and halfword lanes inside the word.
    if (model == word_invariant_big_endian)
    begin
      if (isHalf)
      begin
        lane = {~effAddr[1], effAddr[0]};
      end
      else if (!isWord)
      begin
        lane = ~effAddr[1:0];
      end
    end
    itemBytes = isWord ? 2'd3 : (isHalf ? 2'd1 : 2'd0);
    case (itemBytes)
      2'd0: bytesMask = 4'b0001;
      2'd1: bytesMask = 4'b0011;
      default: bytesMask = 4'b1111;
    endcase
  end

  // -----------------------------------------------------------------
  // Lane steering
  // -----------------------------------------------------------------
  logic [31:0] storeItem;
  logic [31:0] loadItem;
  logic [31:0] storeShifted;
  logic [31:0] loadShifted;
  logic [31:0] memRotated;
  logic [31:0] storeWrap;
  logic [4:0] shiftAmt;
  logic [7:0] beWide;

  // Reverse bytes within the item for byte-invariant big endian.
  function automatic logic [31:0] swapItem(input logic [31:0] d, input logic half, input logic word);
    logic [31:0] r;
    r = d;
    if (word)
    begin
      r = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
    else if (half)
    begin
      r = {16'h0000, d[7:0], d[15:8]};
    end
    return r;
  endfunction

  // Prepare store data and the shift amount for the chosen lane.
  always_comb
  begin
    shiftAmt = {lane, 3'b000};
    storeItem = req.storeData & {{8{bytesMask[3]}}, {8{bytesMask[2]}}, {8{bytesMask[1]}}, 8'hff};
    if (model == byte_invariant_big_endian)
    begin
      storeItem = swapItem(storeItem, isHalf, isWord);
    end
    // Unaligned words wrap within the word, as a rotated view of memory.
    memRotated = (memReadData >> shiftAmt) | (memReadData << (6'd32 - {1'b0, shiftAmt}));
    // Store bytes pushed past the top lane wrap back into the low lanes.
    storeWrap = (shiftAmt == 5'd0) ? `RESET_DATA : (storeItem >> (6'd32 - {1'b0, shiftAmt}));
    beWide = {4'b0000, bytesMask} << lane;
  end

  lane_shifter #(
    .WIDTH(32)
  ) storeShift (
    .dataIn(storeItem),
    .amount(shiftAmt),
    .shiftLeft(1'b1),
    .dataOut(storeShifted)
  );

  lane_shifter #(
    .WIDTH(32)
  ) loadShift (
    .dataIn(memReadData),
    .amount(shiftAmt),
    .shiftLeft(1'b0),
    .dataOut(loadShifted)
  );

  // Extract the loaded item and zero-extend it.
  always_comb
  begin
    // Halfwords and words off lane 0 read a rotated word, matching the wrapped enables.
    loadItem = ((isWord || isHalf) && lane != 2'b00) ? memRotated : loadShifted;
    if (isHalf)
    begin
      loadItem = {16'h0000, loadItem[15:0]};
    end
    else if (!isWord)
    begin
      loadItem = {24'h00_0000, loadItem[7:0]};
    end
    if (model == byte_invariant_big_endian)
    begin
      loadItem = swapItem(loadItem, isHalf, isWord);
    end
  end

  // -----------------------------------------------------------------
  // Output register
  // -----------------------------------------------------------------
  ls_rsp_s rsp_d;
  ls_rsp_s rsp_q;
  endian_e model_q;

  // Assemble the next response; bad sizes move no data.
  always_comb
  begin
    rsp_d.valid = req.valid;
    rsp_d.isStore = req.isStore;
    rsp_d.addr = {effAddr[31:2], 2'b00};
    rsp_d.byteEnable = (req.valid && sizeOk) ? (beWide[3:0] | beWide[7:4]) : 4'h0;
    rsp_d.storeData = `RESET_DATA;
    if (req.valid && sizeOk && req.isStore)
    begin
      rsp_d.storeData = storeShifted | storeWrap;
    end
    rsp_d.loadData = (req.valid && sizeOk && !req.isStore) ? loadItem : `RESET_DATA;
    rsp_d.sizeError = req.valid && !sizeOk;
    rsp_d.alignError = req.valid && misaligned && (req.multiWord || model == endian_reserved);
  end

  // Register the response and the model.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rsp_q <= '0;
      model_q <= little_endian_model;
    end
    else
    begin
      rsp_q <= rsp_d;
      model_q <= model;
    end
  end

  // Both outputs come straight from flip-flops.
  assign rsp = rsp_q;
  assign endianModel = model_q;
endmodule

// file: bench/mem_model.sv
/*
  Memory model: answers loads with the word at the request's word address.
  Assumes a combinational read in the request cycle.
*/
`timescale 1ns/1ps
module mem_model
(
  input wire ls_align_pkg::ls_req_s req,
  output logic [31:0] memReadData
);
  import ls_align_pkg::*;
  // Idle cycles show the inverse, so stale data never passes for fresh.
  always_comb
  begin
    memReadData = req.addr[2] ? 32'h1122_3344 : 32'hAABB_CCDD;
    if (!req.valid)
    begin
      memReadData = ~memReadData;
    end
  end
endmodule

// file: bench/ls_align_asserts.sv
/*
  Port checker for the load/store formatter.
  Assumes it is bound to the formatter from the bench top.
*/
`timescale 1ns/1ps
module ls_align_asserts
(
  input wire logic clk,
  input wire logic rst,
  input wire logic unalignedAccessEnable,
  input wire logic legacyBigEndian,
  input wire logic dataEndianState,
  input wire ls_align_pkg::ls_req_s req,
  input wire logic [31:0] memReadData,
  input wire ls_align_pkg::ls_rsp_s rsp,
  input wire ls_align_pkg::endian_e endianModel
);
  import ls_align_pkg::*;
  logic le;
  // A valid request under the little-endian selection.
  assign le = req.valid && !legacyBigEndian && !dataEndianState;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_model_select: assert property (1 |=> endianModel == $past({legacyBigEndian, dataEndianState}))
    else $error("endian model mismatch");
  a_size_refused: assert property (req.valid && !(req.size inside {3'h1, 3'h2, 3'h4})
    |=> rsp.sizeError && rsp.byteEnable == 4'h0) else $error("bad size not refused");
  a_byte_zext: assert property (req.valid && !req.isStore && req.size == 3'h1
    |=> rsp.loadData[31:8] == 24'h00_0000) else $error("byte not zero-extended");
  a_word_forced: assert property (req.valid && !unalignedAccessEnable && req.size == 3'h4
    |=> rsp.byteEnable == 4'hF && rsp.addr[1:0] == 2'b00) else $error("word not aligned");
  a_half_forced: assert property (le && !unalignedAccessEnable && req.size == 3'h2
    |=> rsp.byteEnable == ($past(req.addr[1]) ? 4'hC : 4'h3)) else $error("half not aligned");
  a_le_byte_lane: assert property (le && req.size == 3'h1
    |=> rsp.byteEnable == 4'h1 << $past(req.addr[1:0])) else $error("byte lane wrong");
  a_half_exact: assert property (le && unalignedAccessEnable && req.size == 3'h2 && req.addr[1:0] == 2'b01
    |=> rsp.byteEnable == 4'h6) else $error("unaligned half lanes wrong");
  a_load_shift: assert property (le && !req.isStore && req.size == 3'h1 && req.addr[1:0] == 2'b11
    |=> rsp.loadData == {24'h00_0000, $past(memReadData[31:24])}) else $error("load shift wrong");
  a_store_shift: assert property (le && req.isStore && req.size == 3'h1 && req.addr[1:0] == 2'b11
    |=> rsp.storeData == {$past(req.storeData[7:0]), 24'h00_0000}) else $error("store shift wrong");
  c_size_error: cover property (rsp.sizeError);
  c_align_error: cover property (rsp.alignError);
  c_word_big: cover property (endianModel == word_invariant_big_endian && rsp.valid);
endmodule

// file: bench/tb_load_store_align_endian.sv
/*
  Self-checking bench for the load/store formatter.
  Assumes the memory model and checker are compiled before it.
*/
`timescale 1ns/1ps
module tb_load_store_align_endian;
  import ls_align_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ua = 1'b0;
  logic [1:0] bm = 2'b00;
  ls_req_s req = '0;
  logic [31:0] memReadData;
  ls_rsp_s rsp;
  endian_e endianModel;
  int err_total = 0;
  int num_checks = 0;
  mem_model i_mem_model (.req(req), .memReadData(memReadData));
  load_store_align_endian i_load_store_align_endian (.clk(clk), .rst(rst), .unalignedAccessEnable(ua),
    .legacyBigEndian(bm[1]), .dataEndianState(bm[0]), .req(req), .memReadData(memReadData), .rsp(rsp),
    .endianModel(endianModel));
  // Clock at 200 MHz.
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Holds one request for a cycle, back to back; the answer is settled on return.
  task automatic acc(input logic st, input logic mw, input logic [2:0] sz, input logic [31:0] a,
    input logic [31:0] d = 32'h0000_0000);
    req = '{1'b1, st, mw, sz, a, d};
    @(negedge clk);
  endtask
  // Walks a byte through all four lanes, lane three included.
  task automatic t_bytes();
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b0, 1'b0, 3'h1, 32'h0000_0100 + i);
      chk("lanes", 32'h0000_0001 << i, rsp.byteEnable);
      chk("valid", 32'h0000_0001, rsp.valid);
      chk("load", (32'hAABB_CCDD >> (8 * i)) & 32'h0000_00FF, rsp.loadData);
    end
  endtask
  // Misaligned items with unaligned access off.
  task automatic t_forced();
    acc(1'b0, 1'b0, 3'h2, 32'h0000_0101);
    chk("lanes", 32'h0000_0003, rsp.byteEnable);
    chk("load", 32'h0000_CCDD, rsp.loadData);
    acc(1'b0, 1'b0, 3'h2, 32'h0000_0103);
    chk("lanes", 32'h0000_000C, rsp.byteEnable);
    acc(1'b0, 1'b0, 3'h4, 32'h0000_0103);
    chk("load", 32'hAABB_CCDD, rsp.loadData);
    chk("addr", 32'h0000_0100, rsp.addr);
  endtask
  // Every size code; only 1, 2 and 4 are accepted.
  task automatic t_sizes();
    logic [31:0] lanes;
    for (int s = 0; s < 8; s++)
    begin
      lanes = (s == 1) ? 32'h0000_0001 : (s == 2) ? 32'h0000_0003 : (s == 4) ? 32'h0000_000F : 32'h0000_0000;
      acc(1'b0, 1'b0, 3'(s), 32'h0000_0100);
      chk("sizeError", 32'(!(s inside {1, 2, 4})), rsp.sizeError);
      chk("lanes", lanes, rsp.byteEnable);
    end
  endtask
  // Exact-address halfword, then multi-word transfers aligned and not.
  task automatic t_unaligned();
    ua = 1'b1;
    acc(1'b0, 1'b0, 3'h2, 32'h0000_0101);
    chk("lanes", 32'h0000_0006, rsp.byteEnable);
    chk("load", 32'h0000_BBCC, rsp.loadData);
    acc(1'b0, 1'b0, 3'h2, 32'h0000_0103);
    chk("lanes", 32'h0000_0009, rsp.byteEnable);
    chk("load", 32'h0000_DDAA, rsp.loadData);
    chk("addr", 32'h0000_0100, rsp.addr);
    acc(1'b0, 1'b0, 3'h4, 32'h0000_0101);
    chk("lanes", 32'h0000_000F, rsp.byteEnable);
    chk("load", 32'hDDAA_BBCC, rsp.loadData);
    acc(1'b0, 1'b1, 3'h4, 32'h0000_0104);
    chk("alignError", 32'h0, rsp.alignError);
    acc(1'b0, 1'b1, 3'h4, 32'h0000_0102);
    chk("alignError", 32'h1, rsp.alignError);
    ua = 1'b0;
  endtask
  // All four byte-order selections, then stores in two of them.
  task automatic t_endian();
    logic [31:0] eb [4] = '{32'h0000_00DD, 32'h0000_00DD, 32'h0000_00AA, 32'h0000_00DD};
    logic [31:0] eh [4] = '{32'h0000_CCDD, 32'h0000_DDCC, 32'h0000_AABB, 32'h0000_CCDD};
    for (int m = 0; m < 4; m++)
    begin
      bm = 2'(m);
      acc(1'b0, 1'b0, 3'h1, 32'h0000_0100);
      chk("model", 32'(m), endianModel);
      chk("load", eb[m], rsp.loadData);
      acc(1'b0, 1'b0, 3'h2, 32'h0000_0100);
      chk("load", eh[m], rsp.loadData);
    end
    bm = 2'b01;
    acc(1'b1, 1'b0, 3'h2, 32'h0000_0102, 32'h0000_1234);
    chk("store", 32'h3412_0000, rsp.storeData);
    bm = 2'b00;
    acc(1'b1, 1'b0, 3'h1, 32'h0000_0103, 32'h0000_005A);
    chk("store", 32'h5A00_0000, rsp.storeData);
    chk("isStore", 32'h0000_0001, rsp.isStore);
  endtask
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (err_total == 0 && num_checks > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence after eight cycles of reset.
  initial
  begin
    // A live request and the reserved selection stand through reset; neither may leak out.
    req = '{1'b1, 1'b0, 1'b0, 3'h1, 32'h0000_0103, 32'h0000_0000};
    bm = 2'b11;
    repeat (8) @(negedge clk);
    chk("resetValid", 32'h0000_0000, rsp.valid);
    chk("resetModel", 32'h0000_0000, endianModel);
    bm = 2'b00;
    rst = 1'b0;
    t_bytes();
    t_forced();
    t_sizes();
    t_unaligned();
    t_endian();
    req = '0;
    @(negedge clk);
    chk("valid", 32'h0000_0000, rsp.valid);
    complete_run();
  end
  // Watchdog well beyond the thirty-nine cycles the tests need.
  initial
  begin
    #5000;
    err_total++;
    complete_run();
  end
endmodule
bind load_store_align_endian ls_align_asserts i_ls_align_asserts (.clk(clk), .rst(rst),
  .unalignedAccessEnable(unalignedAccessEnable), .legacyBigEndian(legacyBigEndian),
  .dataEndianState(dataEndianState), .req(req), .memReadData(memReadData), .rsp(rsp), .endianModel(endianModel));
